// [include/query_regs.vh]
`ifndef QUERY_REGS_VH
`define QUERY_REGS_VH
// register byte addresses
`define ADDR_RX      8'h00
`define ADDR_TX      8'h04
`define ADDR_STAT    8'h08
`define ADDR_PWR     8'h0c
`define ADDR_COND    8'h10
`define ADDR_RELAY   8'h14
`define ADDR_PERIOD  8'h18
`define ADDR_TS      8'h1c
`define ADDR_RDG0    8'h20
`define RDG_COUNT    3'h6
// reset values and field limits
`define PWR_MASK     8'h3f
`define PERIOD_DEF   6'h01
`define PERIOD_MIN   8'h01
`define PERIOD_MAX   8'h3c
`define COND_LAST    4'hb
`define CMD_DEPTH    4'h8
// timing
`define CLK_PERIOD_NS 4
`define TS_TICK_NS    10000000
// cycles of 4 ns in one 10 ms stamp interval, sized for the divider
`define TICK_CYCLES   22'd2500000
// characters
`define CH_AT        8'h40
`define CH_CR        8'h0d
`define CH_Q         8'h3f
`define CH_COLON     8'h3a
`define CH_SP        8'h20
`define CH_COMMA     8'h2c
// bus answers
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// [design/tstamp_counter.v]
`timescale 1ns/1ps
`default_nettype none
`include "query_regs.vh"
module tstamp_counter
#(
   parameter [21:0] TICK_CYCLES = `TICK_CYCLES
)
(
   input  wire        aclk,
   input  wire        aresetn,
   output wire [15:0] count
);
   reg [21:0] div_ff;
   reg [15:0] count_ff;

   assign count = count_ff;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_ff   <= 22'h0;
         count_ff <= 16'h0;
      end
      else if (div_ff == TICK_CYCLES - 22'h1)
      begin
         div_ff   <= 22'h0;
         count_ff <= count_ff + 16'h1;
      end
      else
         div_ff <= div_ff + 22'h1;
   end
endmodule // tstamp_counter
`default_nettype wire

// [design/leak_average.v]
`timescale 1ns/1ps
`default_nettype none
`include "query_regs.vh"
module leak_average
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [5:0]  period,
   input  wire        clear,
   input  wire        smp_we,
   input  wire [2:0]  smp_ch,
   input  wire [15:0] smp_val,
   input  wire [2:0]  rd_ch,
   output wire [15:0] rd_rate
);
   reg [15:0] hist [0:383];
   reg [5:0]  wp_ff [0:5];
   reg [15:0] rate_ff [0:5];
   reg [5:0]  full_ff;
   integer    i;

   wire [8:0]  slot = {smp_ch, wp_ff[smp_ch]};
   wire [15:0] oldest = hist[slot];

   assign rd_rate = rate_ff[rd_ch];

   always @(posedge aclk)
      if (smp_we)
         hist[slot] <= smp_val;

   always @(posedge aclk)
   begin
      if (!aresetn || clear)
      begin
         full_ff <= 6'h0;
         for (i = 0; i < 6; i = i + 1)
         begin
            wp_ff[i]   <= 6'h0;
            rate_ff[i] <= 16'h0;
         end
      end
      else if (smp_we)
      begin
         // oldest sample replaced, rate rebuilt over the window
         if (full_ff[smp_ch])
            rate_ff[smp_ch] <= smp_val - oldest;
         if (wp_ff[smp_ch] == period - 6'h1)
         begin
            wp_ff[smp_ch]   <= 6'h0;
            full_ff[smp_ch] <= 1'b1;
         end
         else
            wp_ff[smp_ch] <= wp_ff[smp_ch] + 6'h1;
      end
   end
endmodule // leak_average
`default_nettype wire

// [design/query_interpreter.v]
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "query_regs.vh"
// Overview of operation
// - 16-bit time stamp advances once per 10 ms
// - time stamp wraps from 65535 back to zero
// - time stamp reading query returns reading plus current time stamp
// - reply echoes selector and unit, colon, E, D or T
// - leak period accepted 1 to 60 s, default 1
// - one leak period shared by all channels
// - leak rate moving average, oldest sample replaced, rate recomputed
// - 606 plus channel and ? answered with header, colon, rate
// - 608 channel status takes digits 1 to 6, 5 and 6 dual
// - status reply carries condition letter A to L
// - reading included only for condition A or B
// - 609 blank ? answered with status byte in hex
// - power-up faults on bits 0 to 5, bits 6 and 7 reserved
// - fault bits OR-combined, zero means no errors
// - two digits, high nibble first
// - 70 queries 1 to 6, parameter ignored, optional checksum
// - every response ends with carriage return
module query_interpreter
#(
   parameter [21:0] TICK_CYCLES = `TICK_CYCLES
)
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output wire        awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output wire        wready,
   output wire [1:0]  bresp,
   output wire        bvalid,
   input  wire        bready,
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output wire        arready,
   output wire [31:0] rdata,
   output wire [1:0]  rresp,
   output wire        rvalid,
   input  wire        rready
);
   reg        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   reg [1:0]  bresp_ff, rresp_ff;
   reg [31:0] rdata_ff;
   reg [7:0]  cmd_ff [0:7];
   reg [3:0]  len_ff;
   reg        inframe_ff;
   reg        rsp_ff;
   reg [3:0]  idx_ff;
   reg [71:0] pl_ff;
   reg [3:0]  plen_ff;
   reg [7:0]  pwr_ff;
   reg [23:0] cond_ff;
   reg [15:0] relay_ff;
   reg [5:0]  period_ff;
   reg [15:0] rdg_ff [0:5];
   integer    i;

   wire [15:0] ts;
   wire [15:0] rate;

   assign awready = awready_ff;
   assign wready  = wready_ff;
   assign bvalid  = bvalid_ff;
   assign bresp   = bresp_ff;
   assign arready = arready_ff;
   assign rvalid  = rvalid_ff;
   assign rdata   = rdata_ff;
   assign rresp   = rresp_ff;

   function [7:0] hexc;
      input [3:0] n;
      begin
         hexc = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
      end
   endfunction

   function [31:0] hex4;
      input [15:0] v;
      begin
         hex4 = {hexc(v[15:12]), hexc(v[11:8]), hexc(v[7:4]), hexc(v[3:0])};
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer      k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1)
            if (strb[k])
               merge[8*k +: 8] = nw[8*k +: 8];
      end
   endfunction

   function is_dig;
      input [7:0] c;
      begin
         is_dig = (c >= 8'h30) && (c <= 8'h39);
      end
   endfunction

   // bus write and read strobes
   wire       wr_en  = awready_ff & awvalid & wready_ff & wvalid;
   wire       rd_en  = arready_ff & arvalid;
   wire       wr_rdg = (awaddr[7:5] == 3'h1) && (awaddr[4:2] < `RDG_COUNT)
                       && (awaddr[1:0] == 2'h0);
   wire [2:0] wr_ri  = awaddr[4:2];
   wire       rx_we  = wr_en && (awaddr == `ADDR_RX) && wstrb[0] && !rsp_ff;
   wire [7:0] rx_b   = wdata[7:0];
   wire [31:0] pwr_mrg  = merge({24'h0, pwr_ff}, wdata, wstrb);
   wire [31:0] cond_mrg = merge({8'h0, cond_ff}, wdata, wstrb);
   wire [31:0] rly_mrg  = merge({16'h0, relay_ff}, wdata, wstrb);
   wire [31:0] rdg_mrg  = merge({16'h0, rdg_ff[wr_ri]}, wdata, wstrb);
   wire       rx_cr  = rx_we && inframe_ff && (rx_b == `CH_CR);

   // command field decode
   wire [7:0] c0 = cmd_ff[0];
   wire [7:0] c1 = cmd_ff[1];
   wire [7:0] c2 = cmd_ff[2];
   wire [7:0] c3 = cmd_ff[3];
   wire [7:0] c4 = cmd_ff[4];
   wire       ch_ok = (c3 >= 8'h31) && (c3 <= 8'h36);
   wire [2:0] chs   = ch_ok ? c3[2:0] - 3'h1 : 3'h0;
   wire [1:0] unit  = c3[1:0] - 2'h1;
   wire [1:0] rst_a = relay_ff[{unit, 1'b0} +: 2];
   wire [1:0] rst_b = relay_ff[{1'b1, unit, 1'b0} +: 2];
   wire [3:0] code  = cond_ff[{chs, 2'h0} +: 4];
   wire [7:0] cletr = (code > `COND_LAST) ? 8'h4c : 8'h41 + {4'h0, code};
   wire [15:0] rdg  = rdg_ff[chs];
   wire [7:0] pwr_v = pwr_ff & `PWR_MASK;
   wire [7:0] d1    = c4 == `CH_COLON ? cmd_ff[5] - 8'h30 : 8'h0;
   wire [7:0] d2    = cmd_ff[6] - 8'h30;
   wire       q_at4 = (c4 == `CH_Q) && (len_ff == 4'h5);

   reg        dec_rsp, dec_set;
   reg [71:0] dec_pl;
   reg [3:0]  dec_plen;
   reg [7:0]  dec_per;
   reg [1:0]  st;

   always @*
   begin
      dec_rsp  = 1'b0;
      dec_set  = 1'b0;
      dec_pl   = 72'h0;
      dec_plen = 4'h0;
      dec_per  = 8'h0;
      st       = (c2 == 8'h41) ? rst_a : rst_b;
      if (c0 == 8'h36 && c1 == 8'h30 && (c2 == 8'h41 || c2 == 8'h42)
          && c3 >= 8'h41 && c3 <= 8'h44 && q_at4)
      begin
         dec_rsp  = 1'b1;
         dec_plen = 4'h1;
         dec_pl[71:64] = (st == 2'h0) ? 8'h45 :
                         (st == 2'h1) ? 8'h44 : 8'h54;
      end
      else if (c0 == 8'h36 && c1 == 8'h30 && c2 == 8'h31 && ch_ok && q_at4)
      begin
         dec_rsp  = 1'b1;
         dec_plen = 4'h9;
         dec_pl   = {hex4(rdg), `CH_COMMA, hex4(ts)};
      end
      else if (c0 == 8'h36 && c1 == 8'h30 && c2 == 8'h36 && ch_ok && q_at4)
      begin
         dec_rsp  = 1'b1;
         dec_plen = 4'h4;
         dec_pl[71:40] = hex4(rate);
      end
      else if (c0 == 8'h36 && c1 == 8'h30 && c2 == 8'h38 && ch_ok && q_at4)
      begin
         dec_rsp = 1'b1;
         dec_pl[71:64] = cletr;
         if (code < 4'h2)
         begin
            dec_plen = 4'h5;
            dec_pl[63:32] = hex4(rdg);
         end
         else
            dec_plen = 4'h1;
      end
      else if (c0 == 8'h36 && c1 == 8'h30 && c2 == 8'h39
               && c3 == `CH_SP && q_at4)
      begin
         dec_rsp  = 1'b1;
         dec_plen = 4'h2;
         dec_pl[71:56] = {hexc(pwr_v[7:4]), hexc(pwr_v[3:0])};
      end
      else if (c0 == 8'h35 && c1 == 8'h30 && c2 == 8'h37 && c3 == `CH_SP
               && c4 == `CH_COLON && is_dig(cmd_ff[5]))
      begin
         if (len_ff == 4'h6)
            dec_per = d1;
         else if (len_ff == 4'h7 && is_dig(cmd_ff[6]))
            dec_per = d1 * 8'ha + d2;
         dec_set = (dec_per >= `PERIOD_MIN) && (dec_per <= `PERIOD_MAX);
      end
      else if (c0 == 8'h37 && c1 == 8'h30 && c2 >= 8'h31 && c2 <= 8'h36
               && c4 == `CH_Q && (len_ff == 4'h5 || len_ff == 4'h7))
         dec_rsp = 1'b1;
   end

   // response character at the current position
   wire [3:0]  pl_k    = idx_ff - 4'h6;
   wire [71:0] pl_sh   = pl_ff << {pl_k, 3'h0};
   wire [3:0]  idx_m1  = idx_ff - 4'h1;
   wire        tx_last = idx_ff == 4'h6 + plen_ff;
   reg  [7:0]  tx_char;

   always @*
   begin
      if (idx_ff == 4'h0)
         tx_char = `CH_AT;
      else if (idx_ff < 4'h5)
         tx_char = cmd_ff[idx_m1[2:0]];
      else if (idx_ff == 4'h5)
         tx_char = `CH_COLON;
      else if (!tx_last)
         tx_char = pl_sh[71:64];
      else
         tx_char = `CH_CR;
   end

   reg [31:0] rd_mux;
   reg        rd_ok;

   always @*
   begin
      rd_ok  = 1'b1;
      rd_mux = 32'h0;
      case (araddr)
         `ADDR_RX:     rd_mux = 32'h0;
         `ADDR_TX:     rd_mux = {23'h0, rsp_ff, rsp_ff ? tx_char : 8'h0};
         `ADDR_STAT:   rd_mux = {30'h0, inframe_ff, rsp_ff};
         `ADDR_PWR:    rd_mux = {24'h0, pwr_v};
         `ADDR_COND:   rd_mux = {8'h0, cond_ff};
         `ADDR_RELAY:  rd_mux = {16'h0, relay_ff};
         `ADDR_PERIOD: rd_mux = {26'h0, period_ff};
         `ADDR_TS:     rd_mux = {16'h0, ts};
         default:
            if (araddr[7:5] == 3'h1 && araddr[4:2] < `RDG_COUNT
                && araddr[1:0] == 2'h0)
               rd_mux = {16'h0, rdg_ff[araddr[4:2]]};
            else
               rd_ok = 1'b0;
      endcase
   end

   // bus handshakes
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= `RESP_OKAY;
         rdata_ff   <= 32'h0;
      end
      else
      begin
         awready_ff <= !awready_ff && !bvalid_ff && awvalid && wvalid;
         wready_ff  <= !wready_ff && !bvalid_ff && awvalid && wvalid;
         if (wr_en)
         begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (awaddr[7:2] <= 6'h0d && awaddr[1:0] == 2'h0
                          && awaddr != `ADDR_TX && awaddr != `ADDR_STAT
                          && awaddr != `ADDR_TS && awaddr != `ADDR_PERIOD)
                         ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (bready)
            bvalid_ff <= 1'b0;
         arready_ff <= !arready_ff && !rvalid_ff && arvalid;
         if (rd_en)
         begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (rready)
            rvalid_ff <= 1'b0;
      end
   end

   // command assembly, response hand-out and settings
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         len_ff     <= 4'h0;
         inframe_ff <= 1'b0;
         rsp_ff     <= 1'b0;
         idx_ff     <= 4'h0;
         pl_ff      <= 72'h0;
         plen_ff    <= 4'h0;
         pwr_ff     <= 8'h0;
         cond_ff    <= 24'h0;
         relay_ff   <= 16'h0;
         period_ff  <= `PERIOD_DEF;
         for (i = 0; i < 8; i = i + 1)
            cmd_ff[i] <= 8'h0;
         for (i = 0; i < 6; i = i + 1)
            rdg_ff[i] <= 16'h0;
      end
      else
      begin
         if (rx_we)
         begin
            if (rx_b == `CH_AT)
            begin
               inframe_ff <= 1'b1;
               len_ff     <= 4'h0;
            end
            else if (rx_cr || (inframe_ff && len_ff == `CMD_DEPTH))
               inframe_ff <= 1'b0;
            else if (inframe_ff)
            begin
               cmd_ff[len_ff[2:0]] <= rx_b;
               len_ff <= len_ff + 4'h1;
            end
         end
         if (rx_cr && dec_rsp)
         begin
            rsp_ff  <= 1'b1;
            idx_ff  <= 4'h0;
            pl_ff   <= dec_pl;
            plen_ff <= dec_plen;
         end
         else if (rd_en && araddr == `ADDR_TX && rsp_ff)
         begin
            if (tx_last)
               rsp_ff <= 1'b0;
            else
               idx_ff <= idx_ff + 4'h1;
         end
         if (rx_cr && dec_set)
            period_ff <= dec_per[5:0];
         if (wr_en && awaddr == `ADDR_PWR)
            pwr_ff <= pwr_mrg[7:0] & `PWR_MASK;
         if (wr_en && awaddr == `ADDR_COND)
            cond_ff <= cond_mrg[23:0];
         if (wr_en && awaddr == `ADDR_RELAY)
            relay_ff <= rly_mrg[15:0];
         if (wr_en && wr_rdg)
            rdg_ff[wr_ri] <= rdg_mrg[15:0];
      end
   end

   tstamp_counter #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_ts (
      .aclk    (aclk),
      .aresetn (aresetn),
      .count   (ts)
   );

   leak_average u_leak (
      .aclk    (aclk),
      .aresetn (aresetn),
      .period  (period_ff),
      .clear   (rx_cr && dec_set),
      .smp_we  (wr_en && wr_rdg),
      .smp_ch  (wr_ri),
      .smp_val (wdata[15:0]),
      .rd_ch   (chs),
      .rd_rate (rate)
   );
endmodule // query_interpreter
`default_nettype wire

// [verif/host_master.sv]
`timescale 1ns/1ps
`default_nettype none
module host_master
(
   input  wire logic        aclk,
   output logic      [7:0]  awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic      [31:0] wdata,
   output logic      [3:0]  wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic      [7:0]  araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end

   // answer 2'h3 marks a handshake that never came
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] r);
      int n;
      n = 0;
      r = 2'h3;
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // each channel released at the edge that takes it
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (((awvalid && !awready) || (wvalid && !wready)) && ++n < 50);
      // late bready makes the slave hold its answer a cycle
      @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid && ++n < 50);
      bready <= 1'b0;
      if (n < 50)
         r = bresp;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] r);
      int n;
      n = 0;
      r = 2'h3;
      v = 32'h0;
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready && ++n < 50);
      arvalid <= 1'b0;
      @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid && ++n < 50);
      rready <= 1'b0;
      v = rdata;
      if (n < 50)
         r = rresp;
   endtask
endmodule // host_master
`default_nettype wire

// [verif/query_interpreter_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "query_regs.vh"
module query_interpreter_properties
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  awaddr,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0]  wstrb,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [7:0]  araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready
);
   logic [7:0] rd_addr_ff;

   always @(posedge aclk)
      if (!aresetn)
         rd_addr_ff <= 8'h0;
      else if (arvalid && arready)
         rd_addr_ff <= araddr;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence wr_take;
      awvalid && wvalid && awready && wready;
   endsequence
   sequence rd_take;
      arvalid && arready;
   endsequence

   a_ready_pair: assert property (awready |-> wready && awvalid && wvalid)
      else $error("write ready without both channels");
   a_write_answer: assert property (wr_take |=> bvalid && !awready)
      else $error("write answer late");
   a_read_answer: assert property (rd_take |=> rvalid && !arready)
      else $error("read answer late");
   a_bresp_hold: assert property (bvalid && !bready |=>
      bvalid && $stable(bresp)) else $error("write answer dropped");
   a_rdata_hold: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer dropped");
   a_read_once: assert property (rvalid && rready |=> !rvalid)
      else $error("read answer repeated");
   a_refused_zero: assert property (rvalid && rresp == `RESP_SLVERR |->
      rdata == 32'h0) else $error("refused read data");
   a_pwr_reserved: assert property (rvalid && rd_addr_ff == `ADDR_PWR |->
      rdata[31:6] == 26'h0) else $error("fault reserved bits set");
   a_ts_width: assert property (rvalid && rd_addr_ff == `ADDR_TS |->
      rdata[31:16] == 16'h0) else $error("stamp wider than 16 bits");
   a_period_range: assert property (rvalid && rd_addr_ff == `ADDR_PERIOD
      |-> rdata >= 32'h1 && rdata <= 32'h3c) else $error("period range");
endmodule // query_interpreter_properties

bind query_interpreter query_interpreter_properties u_props
(
   .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
   .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
   .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
   .araddr(araddr), .arvalid(arvalid), .arready(arready),
   .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
);
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "query_regs.vh"
module testbench;
   logic        aclk;
   logic        aresetn;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   int          bad_count = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   string       t;

   query_interpreter #(.TICK_CYCLES(22'd1)) DUT
   (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );
   host_master host
   (
      .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );

   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) cyc <= cyc + 1;

   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic hang;
      bad_count++;
      $display("CHECK FAILED handshake exp answer got none");
      final_report();
   endtask
   task automatic cmp_w(string n, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e)
         bad_count++;
      if (g !== e)
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
   endtask
   task automatic cmp_s(string n, string e, string g);
      samples_checked++;
      if (g != e)
         bad_count++;
      if (g != e)
         $display("CHECK FAILED %s exp %s got %s", n, e, g);
   endtask
   task automatic w(logic [7:0] a, logic [31:0] v, logic [1:0] e);
      host.wr(a, v, r);
      if (r === 2'h3)
         hang();
      cmp_w("bresp", 32'(e), 32'(r));
   endtask
   task automatic g(logic [7:0] a, output logic [31:0] v);
      host.rd(a, v, r);
      if (r === 2'h3)
         hang();
   endtask
   task automatic send(string s);
      for (int i = 0; i < s.len(); i++)
         w(`ADDR_RX, 32'(s[i]), `RESP_OKAY);
   endtask
   task automatic get(output string s);
      s = "";
      for (int i = 0; i < 20; i++)
      begin
         g(`ADDR_TX, d);
         if (d[8] !== 1'b1)
            break;
         s = $sformatf("%s%c", s, d[7:0]);
         if (d[7:0] === `CH_CR)
            break;
      end
   endtask
   task automatic q(string c, string e);
      send(c);
      get(t);
      cmp_s(c, e, t);
   endtask

   task automatic t_stamp;
      logic [31:0] d1;
      int          c1;
      g(`ADDR_TS, d1);
      c1 = cyc;
      cmp_w("ts after reset", 32'h1, 32'(d1 < 16));
      repeat (1000) @(posedge aclk);
      g(`ADDR_TS, d);
      cmp_w("ts step", 32'(16'(d1 + cyc - c1)), d);
      repeat (65000) @(posedge aclk);
      g(`ADDR_TS, d);
      cmp_w("ts wrap", 32'(16'(d1 + cyc - c1)), d);
      $display("test stamp done");
   endtask
   task automatic t_regs;
      g(`ADDR_PERIOD, d);
      cmp_w("period", 32'h1, d);
      g(`ADDR_STAT, d);
      cmp_w("stat", 32'h0, d);
      g(8'h40, d);
      cmp_w("rresp", 32'(`RESP_SLVERR), 32'(r));
      w(`ADDR_TS, 32'h5, `RESP_SLVERR);
      w(`ADDR_PWR, 32'hff, `RESP_OKAY);
      g(`ADDR_PWR, d);
      cmp_w("pwr", 32'h3f, d);
      $display("test regs done");
   endtask
   task automatic t_relay;
      string st = "EDTTTTDE";
      string c;
      w(`ADDR_RELAY, 32'h1be4, `RESP_OKAY);
      for (int k = 0; k < 8; k++)
      begin
         c = $sformatf("@60%c%c", 8'h41 + k / 4, 8'h41 + k % 4);
         q({c, "?\r"}, $sformatf("%s:%c\r", c, st[k]));
      end
      $display("test relay done");
   endtask
   task automatic t_power;
      logic [7:0] pv [4] = '{8'hff, 8'h28, 8'h0c, 8'h00};
      string      px [4] = '{"3F", "28", "0C", "00"};
      for (int i = 0; i < 4; i++)
      begin
         w(`ADDR_PWR, 32'(pv[i]), `RESP_OKAY);
         q("@609 ?\r", {"@609 :", px[i], "\r"});
      end
      $display("test power done");
   endtask
   task automatic t_status;
      string sx [6] = '{"A1231", "B1232", "K", "L", "C", "L"};
      string c, e;
      w(`ADDR_COND, 32'h00f2ba10, `RESP_OKAY);
      for (int n = 1; n <= 6; n++)
      begin
         w(`ADDR_RDG0 + 8'(4 * n - 4), 32'h1230 + n, `RESP_OKAY);
         c = $sformatf("@608%0d?\r", n);
         e = $sformatf("@608%0d:%s\r", n, sx[n - 1]);
         q(c, e);
      end
      send("@6013?\r");
      get(t);
      cmp_s("stamped", "@6013:1233,", t.substr(0, 10));
      cmp_w("stamped len", 32'd16, 32'(t.len()));
      $display("test status done");
   endtask
   task automatic t_leak;
      logic [15:0] sa [5] = '{16'h10, 16'h20, 16'h40, 16'h80, 16'h100};
      logic [15:0] sb [5] = '{16'h1, 16'h2, 16'h3, 16'h4, 16'h9};
      send("@507 :3\r");
      send("@507 :61\r");
      g(`ADDR_PERIOD, d);
      cmp_w("period", 32'h3, d);
      for (int i = 0; i < 5; i++)
      begin
         w(`ADDR_RDG0 + 8'h4, 32'(sa[i]), `RESP_OKAY);
         w(`ADDR_RDG0 + 8'h8, 32'(sb[i]), `RESP_OKAY);
      end
      q("@6062?\r", "@6062:00E0\r");
      q("@6063?\r", "@6063:0007\r");
      send("@507 :3\r");
      q("@6062?\r", "@6062:0000\r");
      send("@507 :12\r");
      g(`ADDR_PERIOD, d);
      cmp_w("period two digits", 32'hc, d);
      $display("test leak done");
   endtask
   task automatic t_other;
      string c;
      for (int n = 1; n <= 6; n++)
      begin
         c = $sformatf("@70%0d%c", n, 8'h60 + n);
         q({c, "?\r"}, {c, ":\r"});
      end
      q("@7034?5a\r", "@7034:\r");
      $display("test status category done");
   endtask

   initial
   begin
      aresetn = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_stamp();
      t_regs();
      t_relay();
      t_power();
      t_status();
      t_leak();
      t_other();
      final_report();
   end
endmodule // testbench
`default_nettype wire
